//--- cdpf_defines.svh
// Purpose: named constants for the configurable dual-port / fifo memory block
// Assumes: included by bare name from the package and the design file
// Notes:   widths are fixed; only sizes, masks, reset values, the x8 width code and a 13-bit one live here
`ifndef CDPF_DEFINES_SVH
`define CDPF_DEFINES_SVH
`define CDPF_CH_BYTES   512       // channel block storage, bytes (4096 bits)
`define CDPF_CL_BYTES   1024      // cluster block storage, bytes (8192 bits)
`define CDPF_CH_WORDS   13'h1000  // channel depth in x1 words
`define CDPF_ADDR_ALL   12'hFFF   // channel word address mask for x1
`define CDPF_ZERO3      3'h0
`define CDPF_ZERO8      8'h00
`define CDPF_ZERO12     12'h000
`define CDPF_ZERO13     13'h0000
`define CDPF_ONE13      13'h0001
`define CDPF_W_SHIFT    2'h3      // x8 width code, used for byte index shifts
`endif

//--- cdpf_pkg.sv
// Purpose: types and lane helpers shared by the memory blocks
// Assumes: byte-wide storage; narrow words are lanes inside one byte
// Notes:   width code n means a word of 2**n bits
`include "cdpf_defines.svh"
package cdpf_pkg;
  // channel block configuration
  typedef enum logic [1:0] {
    CDPF_DPRAM = 2'b00,
    CDPF_SPRAM = 2'b01,
    CDPF_ROM   = 2'b10,
    CDPF_FIFO  = 2'b11
  } cdpf_mode_t;
  // word organisation
  typedef enum logic [1:0] {
    CDPF_X1 = 2'b00,
    CDPF_X2 = 2'b01,
    CDPF_X4 = 2'b10,
    CDPF_X8 = 2'b11
  } cdpf_width_t;
  // byte holding a word
  function automatic logic [9:0] cdpf_byte(input logic [12:0] addr, input cdpf_width_t w);
    cdpf_byte = 10'(addr >> (`CDPF_W_SHIFT - w));
  endfunction
  // bit offset of a word inside its byte
  function automatic logic [2:0] cdpf_off(input logic [12:0] addr, input cdpf_width_t w);
    cdpf_off = 3'(addr << w);
  endfunction
  // lane mask for a width
  function automatic logic [7:0] cdpf_mask(input cdpf_width_t w);
    case (w)
      CDPF_X1: cdpf_mask = 8'h01;
      CDPF_X2: cdpf_mask = 8'h03;
      CDPF_X4: cdpf_mask = 8'h0F;
      default: cdpf_mask = 8'hFF;
    endcase
  endfunction
  // extract a word, zero extended
  function automatic logic [7:0] cdpf_lane(input logic [7:0] b, input logic [12:0] addr,
                                           input cdpf_width_t w);
    cdpf_lane = 8'(b >> cdpf_off(addr, w)) & cdpf_mask(w);
  endfunction
  // replace a word inside a byte
  function automatic logic [7:0] cdpf_merge(input logic [7:0] b, input logic [7:0] d,
                                            input logic [12:0] addr, input cdpf_width_t w);
    logic [7:0] m;
    m = 8'(cdpf_mask(w) << cdpf_off(addr, w));
    cdpf_merge = (b & ~m) | (8'((d & cdpf_mask(w)) << cdpf_off(addr, w)) & m);
  endfunction
endpackage

//--- cdpf_mem.sv
// Purpose: channel memory (dual-port ram / sp ram / rom / fifo) plus a cluster ram
// Assumes: all memory clocks arrive as pins and are sampled on CLK_I as edge strobes
// Notes:   memory arrays have no reset; contents come from the configuration port
`timescale 1ns/1ps
`include "cdpf_defines.svh"

module cdpf_spram
  import cdpf_pkg::*;
(
  input  wire logic        clk_i,        // system clock
  input  wire logic        rst_n_i,      // async reset, active low
  input  wire logic        oclr_n_i,     // output register clear, active low
  input  wire logic        in_stb_i,     // selected input clock edge
  input  wire logic        out_stb_i,    // selected output clock edge
  input  wire logic        sync_i,       // 1 synchronous, 0 asynchronous
  input  wire logic        rom_i,        // rom / lookup table mode
  input  wire logic        cfg_i,        // configuration in progress
  input  wire logic        en_i,         // access enable
  input  wire logic        we_i,         // write enable
  input  wire logic [12:0] addr_i,       // word address
  input  wire logic [7:0]  din_i,        // write data
  input  cdpf_width_t      width_i,      // organisation
  input  wire logic        oreg_en_i,    // use output register
  input  wire logic        cfg_we_i,     // configuration byte write
  input  wire logic [9:0]  cfg_addr_i,   // configuration byte address
  input  wire logic [7:0]  cfg_data_i,   // configuration byte
  output logic      [7:0]  dout_o        // read data
);
  logic [7:0]  mem [`CDPF_CL_BYTES];     // storage, no reset
  logic [12:0] hold_r;                   // registered read address
  logic [7:0]  rd_r;                     // read data
  logic [7:0]  oreg_r;                   // optional output register
  // access strobe: clock edge in sync mode, level in async mode
  wire         go    = ~cfg_i & (sync_i ? (in_stb_i & en_i) : en_i);
  wire         wr    = go & we_i & ~rom_i;
  wire  [12:0] raddr = (sync_i & ~go) ? hold_r : addr_i;
  wire  [9:0]  wi    = cdpf_byte(addr_i, width_i);
  wire  [9:0]  ri    = cdpf_byte(raddr, width_i);

  // storage: configuration load, then user writes
  always_ff @(posedge clk_i) begin
    if (cfg_we_i) begin
      mem[cfg_addr_i] <= cfg_data_i;
    end else if (wr) begin
      mem[wi] <= cdpf_merge(mem[wi], din_i, addr_i, width_i);
    end
  end

  // read path, refreshed every cycle; sync mode re-reads the held address between strobes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_r <= {1'b0, `CDPF_ZERO12};
      rd_r   <= `CDPF_ZERO8;
    end else begin
      hold_r <= raddr;
      rd_r   <= cdpf_lane(mem[ri], raddr, width_i);
    end
  end

  // output register on its own clock, cleared without the clock
  always_ff @(posedge clk_i or negedge oclr_n_i) begin
    if (!oclr_n_i) begin
      oreg_r <= `CDPF_ZERO8;
    end else if (out_stb_i) begin
      oreg_r <= rd_r;
    end
  end

  assign dout_o = oreg_en_i ? oreg_r : rd_r;
endmodule

module cdpf_mem
  import cdpf_pkg::*;
(
  input  wire logic        CLK_I,                    // system clock
  input  wire logic        RSTN_I,                   // async reset, active low
  input  wire logic [3:0]  GLOBAL_CLOCK_LINES_I,     // global clocks (pins)
  input  wire logic        H_LOCAL_CLK_I,            // channel local clock, horizontal
  input  wire logic        V_LOCAL_CLK_I,            // channel local clock, vertical
  input  wire logic        CL_IN_LOCAL_CLK_I,        // cluster input-register local clock
  input  wire logic        CL_OUT_LOCAL_CLK_I,       // cluster output-register local clock
  input  wire logic        CFG_I,                    // configuration phase
  input  wire logic        CFG_WE_I,                 // configuration byte write
  input  wire logic        CFG_SEL_I,                // 0 channel, 1 cluster
  input  wire logic [9:0]  CFG_ADDR_I,               // configuration byte address
  input  wire logic [7:0]  CFG_DATA_I,               // configuration byte
  input  cdpf_mode_t       MODE_I,                   // channel mode
  input  cdpf_width_t      WIDTH_I,                  // channel organisation
  input  wire logic        SYNC_I,                   // channel ram synchronous
  input  wire logic [2:0]  A_CLK_SEL_I,              // port A input clock source
  input  wire logic [2:0]  A_OCLK_SEL_I,             // port A output clock source
  input  wire logic        A_CLK_POL_I,              // port A polarity, 1 inverted
  input  wire logic [2:0]  B_CLK_SEL_I,              // port B input clock source
  input  wire logic [2:0]  B_OCLK_SEL_I,             // port B output clock source
  input  wire logic        B_CLK_POL_I,              // port B polarity, 1 inverted
  input  wire logic        A_OREG_EN_I,              // port A output register
  input  wire logic        B_OREG_EN_I,              // port B output register
  input  wire logic        OREG_RST_I,               // channel output register clear
  input  wire logic        A_EN_I,                   // port A enable
  input  wire logic        A_WE_I,                   // port A write / fifo push
  input  wire logic [11:0] A_ADDR_I,                 // port A word address
  input  wire logic [7:0]  A_DATA_I,                 // port A write data
  input  wire logic        B_EN_I,                   // port B enable / fifo pop
  input  wire logic        B_WE_I,                   // port B write
  input  wire logic [11:0] B_ADDR_I,                 // port B word address
  input  wire logic [7:0]  B_DATA_I,                 // port B write data
  input  wire logic [11:0] ALMOST_THR_I,             // almost flag threshold, words
  output logic      [7:0]  A_DATA_O,                 // port A read data
  output logic      [7:0]  B_DATA_O,                 // port B / fifo read data
  output logic             MATCH_N_O,                // address collision, active low
  output logic             EMPTY_OR_FULL_FLAG_N_O,   // fifo empty or full, active low
  output logic             HALF_LEVEL_FLAG_N_O,      // fifo half full, active low
  output logic             ALMOST_LEVEL_FLAG_O,      // fifo almost empty or full
  input  wire logic        CL_ROM_I,                 // cluster rom / lookup table mode
  input  wire logic        CL_SYNC_I,                // cluster synchronous
  input  cdpf_width_t      CL_WIDTH_I,               // cluster organisation
  input  wire logic [2:0]  CL_ICLK_SEL_I,            // cluster input clock source
  input  wire logic        CL_ICLK_POL_I,            // cluster input clock polarity
  input  wire logic [2:0]  CL_OCLK_SEL_I,            // cluster output clock source
  input  wire logic        CL_OCLK_POL_I,            // cluster output clock polarity
  input  wire logic        CL_OREG_EN_I,             // cluster output register
  input  wire logic        CL_OREG_RST_I,            // cluster output register clear
  input  wire logic        CL_EN_I,                  // cluster enable
  input  wire logic        CL_WE_I,                  // cluster write
  input  wire logic [12:0] CL_ADDR_I,                // cluster word address
  input  wire logic [7:0]  CL_DATA_I,                // cluster write data
  output logic      [7:0]  CL_DATA_O                 // cluster read data
);
  // ---- clock source sampling: two flops, then an edge history flop
  logic [7:0] s1_r, s2_r, s3_r;          // synchroniser and history
  wire  [7:0] src  = {CL_OUT_LOCAL_CLK_I, CL_IN_LOCAL_CLK_I, V_LOCAL_CLK_I, H_LOCAL_CLK_I,
                      GLOBAL_CLOCK_LINES_I};
  wire  [7:0] rise = s2_r & ~s3_r;       // true-polarity edges
  wire  [7:0] fall = ~s2_r & s3_r;       // inverted-polarity edges

  // sample all clock pins
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      s1_r <= `CDPF_ZERO8;
      s2_r <= `CDPF_ZERO8;
      s3_r <= `CDPF_ZERO8;
    end else begin
      s1_r <= src;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // per-port edge selection; ports A and B share one polarity for input and output, the cluster has one each
  wire a_edge  = A_CLK_POL_I ? fall[A_CLK_SEL_I] : rise[A_CLK_SEL_I];
  wire a_oedge = A_CLK_POL_I ? fall[A_OCLK_SEL_I] : rise[A_OCLK_SEL_I];
  wire b_edge  = B_CLK_POL_I ? fall[B_CLK_SEL_I] : rise[B_CLK_SEL_I];
  wire b_oedge = B_CLK_POL_I ? fall[B_OCLK_SEL_I] : rise[B_OCLK_SEL_I];
  wire cl_iedge = CL_ICLK_POL_I ? fall[CL_ICLK_SEL_I] : rise[CL_ICLK_SEL_I];
  wire cl_oedge = CL_OCLK_POL_I ? fall[CL_OCLK_SEL_I] : rise[CL_OCLK_SEL_I];

  // ---- channel decode
  logic [7:0]  mem [`CDPF_CH_BYTES];     // channel storage, no reset
  logic [11:0] a_hold_r, b_hold_r;       // registered read addresses
  logic [7:0]  rd_a_r, rd_b_r;           // read data
  logic [7:0]  oreg_a_r, oreg_b_r;       // optional output registers
  logic        pend_r;                   // deferred port B write waiting
  logic [11:0] pend_addr_r;              // deferred write address
  logic [7:0]  pend_data_r;              // deferred write data
  logic [11:0] wptr_r, rptr_r;           // fifo word pointers
  logic [12:0] cnt_r;                    // fifo word count
  wire  dp    = (MODE_I == CDPF_DPRAM);
  wire  rom   = (MODE_I == CDPF_ROM);
  wire  fifo  = (MODE_I == CDPF_FIFO);
  wire  [11:0] wmask = 12'(`CDPF_ADDR_ALL >> (`CDPF_W_SHIFT - WIDTH_I));
  wire  a_go  = ~CFG_I & ~fifo & (SYNC_I ? (a_edge & A_EN_I) : A_EN_I);
  wire  b_go  = ~CFG_I & dp & (SYNC_I ? (b_edge & B_EN_I) : B_EN_I);
  wire  a_wr  = a_go & A_WE_I & ~rom;
  wire  b_wr  = b_go & B_WE_I;
  wire  same  = ((A_ADDR_I & wmask) == (B_ADDR_I & wmask));
  wire  coll  = a_go & b_go & same;      // dp only through b_go
  wire  b_defer = coll & a_wr & b_wr;    // A writes first, B waits a cycle and lands last
  // fifo occupancy
  wire  [12:0] depth = 13'(`CDPF_CH_WORDS >> WIDTH_I);
  wire  empty = (cnt_r == `CDPF_ZERO13);
  wire  full  = (cnt_r == depth);
  wire  push  = fifo & ~CFG_I & a_edge & A_WE_I & ~full;
  wire  pop   = fifo & ~CFG_I & b_edge & B_EN_I & ~empty;
  wire  [12:0] wp_inc = 13'({1'b0, wptr_r} + `CDPF_ONE13);
  wire  [12:0] rp_inc = 13'({1'b0, rptr_r} + `CDPF_ONE13);

  // ---- write chain: pending B first, then A, then B (later wins)
  wire  [11:0] a_waddr = fifo ? wptr_r : A_ADDR_I;
  wire  [7:0]  a_wdata = A_DATA_I;
  wire         a_wrx   = a_wr | push;
  wire         b_wrx   = b_wr & ~b_defer;
  wire  [8:0]  pi = 9'(cdpf_byte({1'b0, pend_addr_r}, WIDTH_I));
  wire  [8:0]  ai = 9'(cdpf_byte({1'b0, a_waddr}, WIDTH_I));
  wire  [8:0]  bi = 9'(cdpf_byte({1'b0, B_ADDR_I}, WIDTH_I));
  wire  [7:0]  pb = cdpf_merge(mem[pi], pend_data_r, {1'b0, pend_addr_r}, WIDTH_I);
  wire  [7:0]  ab_base = (pend_r && ai == pi) ? pb : mem[ai];
  wire  [7:0]  ab = cdpf_merge(ab_base, a_wdata, {1'b0, a_waddr}, WIDTH_I);
  wire  [7:0]  bb_base = (a_wrx && bi == ai) ? ab : ((pend_r && bi == pi) ? pb : mem[bi]);
  wire  [7:0]  bb = cdpf_merge(bb_base, B_DATA_I, {1'b0, B_ADDR_I}, WIDTH_I);

  // channel storage; configuration load blocks user traffic
  always_ff @(posedge CLK_I) begin
    if (CFG_I) begin
      if (CFG_WE_I && !CFG_SEL_I) begin
        mem[CFG_ADDR_I[8:0]] <= CFG_DATA_I;
      end
    end else begin
      if (pend_r) begin
        mem[pi] <= pb;
      end
      if (a_wrx) begin
        mem[ai] <= ab;
      end
      if (b_wrx) begin
        mem[bi] <= bb;
      end
    end
  end

  // ---- read side: strobe cycle reads old data, later cycles re-read held address
  wire  [11:0] a_raddr = (SYNC_I & ~a_go) ? a_hold_r : A_ADDR_I;
  wire  [11:0] b_raddr = fifo ? rptr_r : ((SYNC_I & ~b_go) ? b_hold_r : B_ADDR_I);
  wire  [8:0]  ari = 9'(cdpf_byte({1'b0, a_raddr}, WIDTH_I));
  wire  [8:0]  bri = 9'(cdpf_byte({1'b0, b_raddr}, WIDTH_I));
  wire  [7:0]  a_rd = cdpf_lane(mem[ari], {1'b0, a_raddr}, WIDTH_I);
  wire  [7:0]  b_rd = cdpf_lane(mem[bri], {1'b0, b_raddr}, WIDTH_I);

  // read registers and deferred write
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      a_hold_r    <= `CDPF_ZERO12;
      b_hold_r    <= `CDPF_ZERO12;
      rd_a_r      <= `CDPF_ZERO8;
      rd_b_r      <= `CDPF_ZERO8;
      pend_r      <= 1'b0;
      pend_addr_r <= `CDPF_ZERO12;
      pend_data_r <= `CDPF_ZERO8;
    end else begin
      a_hold_r    <= a_raddr;
      b_hold_r    <= fifo ? b_hold_r : b_raddr;
      rd_a_r      <= a_rd;
      rd_b_r      <= (fifo && !pop) ? rd_b_r : b_rd;
      pend_r      <= b_defer;
      pend_addr_r <= b_defer ? B_ADDR_I : pend_addr_r;
      pend_data_r <= b_defer ? B_DATA_I : pend_data_r;
    end
  end

  // fifo pointers and count, cleared outside fifo mode
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      wptr_r <= `CDPF_ZERO12;
      rptr_r <= `CDPF_ZERO12;
      cnt_r  <= `CDPF_ZERO13;
    end else if (!fifo) begin
      wptr_r <= `CDPF_ZERO12;
      rptr_r <= `CDPF_ZERO12;
      cnt_r  <= `CDPF_ZERO13;
    end else begin
      if (push) begin
        wptr_r <= (wp_inc == depth) ? `CDPF_ZERO12 : wp_inc[11:0];
      end
      if (pop) begin
        rptr_r <= (rp_inc == depth) ? `CDPF_ZERO12 : rp_inc[11:0];
      end
      cnt_r <= 13'(cnt_r + {12'h000, push} - {12'h000, pop});
    end
  end

  // output registers, each on its port's output clock
  wire ch_oclr_n = RSTN_I & ~OREG_RST_I;
  always_ff @(posedge CLK_I or negedge ch_oclr_n) begin
    if (!ch_oclr_n) begin
      oreg_a_r <= `CDPF_ZERO8;
      oreg_b_r <= `CDPF_ZERO8;
    end else begin
      oreg_a_r <= a_oedge ? rd_a_r : oreg_a_r;
      oreg_b_r <= b_oedge ? rd_b_r : oreg_b_r;
    end
  end

  // ---- outputs and flags
  wire [12:0] thr  = {1'b0, ALMOST_THR_I};
  wire        half = (cnt_r >= (depth >> 1));
  wire        alm  = (cnt_r <= thr) | ((thr <= depth) && (cnt_r >= 13'(depth - thr)));
  assign A_DATA_O               = A_OREG_EN_I ? oreg_a_r : rd_a_r;
  assign B_DATA_O               = B_OREG_EN_I ? oreg_b_r : rd_b_r;
  assign MATCH_N_O              = ~coll;
  assign EMPTY_OR_FULL_FLAG_N_O = ~(fifo & (empty | full));
  assign HALF_LEVEL_FLAG_N_O    = ~(fifo & half);
  assign ALMOST_LEVEL_FLAG_O    = fifo & alm;

  // ---- cluster memory
  cdpf_spram u_cluster (
    .clk_i      (CLK_I),
    .rst_n_i    (RSTN_I),
    .oclr_n_i   (RSTN_I & ~CL_OREG_RST_I),
    .in_stb_i   (cl_iedge),
    .out_stb_i  (cl_oedge),
    .sync_i     (CL_SYNC_I),
    .rom_i      (CL_ROM_I),
    .cfg_i      (CFG_I),
    .en_i       (CL_EN_I),
    .we_i       (CL_WE_I),
    .addr_i     (CL_ADDR_I),
    .din_i      (CL_DATA_I),
    .width_i    (CL_WIDTH_I),
    .oreg_en_i  (CL_OREG_EN_I),
    .cfg_we_i   (CFG_I & CFG_WE_I & CFG_SEL_I),
    .cfg_addr_i (CFG_ADDR_I),
    .cfg_data_i (CFG_DATA_I),
    .dout_o     (CL_DATA_O)
  );

  // ---- checks
  AST_MATCH: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (dp && !CFG_I && SYNC_I && a_edge && A_EN_I && b_edge && B_EN_I && same) |-> !MATCH_N_O)
    else $error("collision not flagged");
  AST_NO_PUSH_FULL: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (fifo && full && !pop) |=> ($stable(wptr_r) && cnt_r == $past(cnt_r)))
    else $error("write pointer moved while full");
  AST_NO_POP_EMPTY: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (fifo && empty && !push) |=> $stable(rptr_r))
    else $error("read pointer moved while empty");
  AST_COUNT_UP: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (push && !pop) |=> (cnt_r == 13'($past(cnt_r) + `CDPF_ONE13)))
    else $error("count did not follow push");
  AST_DEFER: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    b_defer |=> (pend_r && pend_addr_r == $past(B_ADDR_I)))
    else $error("port B write not deferred");
  AST_ROM: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (rom && !pend_r) |-> (!a_wrx && !b_wrx))
    else $error("write accepted in rom mode");
  AST_OREG_CLR: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    OREG_RST_I |-> (oreg_a_r == `CDPF_ZERO8 && oreg_b_r == `CDPF_ZERO8))
    else $error("output register not cleared");
  AST_HALF: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (push && !pop && cnt_r == 13'((depth >> 1) - `CDPF_ONE13)) |=> !HALF_LEVEL_FLAG_N_O)
    else $error("half flag late");
  AST_RR: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (coll && !a_wr && !b_wr && WIDTH_I == CDPF_X8) |=> (rd_a_r == rd_b_r))
    else $error("simultaneous reads differ");
  AST_A_WINS: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (coll && a_wr && !B_WE_I && SYNC_I && WIDTH_I == CDPF_X8)
      ##1 (!a_wrx && !b_wrx && !pend_r && !b_go) |=> (rd_b_r == $past(A_DATA_I, 2)))
    else $error("port B did not see port A write");
endmodule

//--- cdpf_user_clk.sv
// Purpose: user-logic clock source that drives the global clock pins
// Assumes: one system clock; the block samples the pins through synchronisers
// Notes:   each line is 3 cycles high and 3 low, wide enough to be synchronised
`timescale 1ns/1ps
module cdpf_user_clk (
  input  wire logic       clk_i,   // system clock
  input  wire logic       rst_n_i, // async reset, active low
  output logic      [3:0] gclk_o   // global clock pins, all in phase
);
  logic [1:0] cnt_r; // half-period counter
  // toggle the pins every third cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r  <= 2'h0;
      gclk_o <= 4'h0;
    end else if (cnt_r == 2'h2) begin
      cnt_r  <= 2'h0;
      gclk_o <= ~gclk_o;
    end else begin
      cnt_r <= cnt_r + 2'h1;
    end
  end
endmodule

//--- configurable_dual_port_fifo_ram_test.sv
// Purpose: self-checking bench for the channel memory block
// Assumes: dual-port tests run async, then sync on global clock 0; fifo uses clock 0
// Notes:   expected data follows from the values the bench writes
`timescale 1ns/1ps
module configurable_dual_port_fifo_ram_test
  import cdpf_pkg::*;
;
  logic CLK_I = 0, RSTN_I = 0, CFG_I = 0, CFG_WE_I = 0, CFG_SEL_I = 0, SYNC_I = 0;
  logic H_LOCAL_CLK_I = 0, V_LOCAL_CLK_I = 0, CL_IN_LOCAL_CLK_I = 0, CL_OUT_LOCAL_CLK_I = 0;
  logic A_CLK_POL_I = 0, B_CLK_POL_I = 0, A_OREG_EN_I = 0, B_OREG_EN_I = 0, OREG_RST_I = 0;
  logic A_EN_I = 0, A_WE_I = 0, B_EN_I = 0, B_WE_I = 0, CL_ROM_I = 0, CL_SYNC_I = 0;
  logic CL_ICLK_POL_I = 0, CL_OCLK_POL_I = 0, CL_OREG_EN_I = 0, CL_OREG_RST_I = 0;
  logic CL_EN_I = 0, CL_WE_I = 0, MATCH_N_O, EMPTY_OR_FULL_FLAG_N_O;
  logic HALF_LEVEL_FLAG_N_O, ALMOST_LEVEL_FLAG_O;
  logic [2:0] A_CLK_SEL_I = '0, A_OCLK_SEL_I = '0, B_CLK_SEL_I = '0, B_OCLK_SEL_I = '0;
  logic [2:0] CL_ICLK_SEL_I = '0, CL_OCLK_SEL_I = '0;
  logic [7:0] A_DATA_I = '0, B_DATA_I = '0, CFG_DATA_I = '0, CL_DATA_I = '0;
  logic [7:0] A_DATA_O, B_DATA_O, CL_DATA_O;
  logic [9:0] CFG_ADDR_I = '0;
  logic [11:0] A_ADDR_I = '0, B_ADDR_I = '0, ALMOST_THR_I = '0;
  logic [12:0] CL_ADDR_I = '0;
  cdpf_mode_t MODE_I = CDPF_DPRAM;
  cdpf_width_t WIDTH_I = CDPF_X8, CL_WIDTH_I = CDPF_X8;
  wire logic [3:0] GLOBAL_CLOCK_LINES_I;
  int fails = 0, n_checks = 0;
  logic [19:0] rows [3] = '{{12'h000, 8'hA5}, {12'h1FF, 8'h5A}, {12'h07E, 8'h81}};
  cdpf_mem dut (.*);
  cdpf_user_clk user_clk (.clk_i(CLK_I), .rst_n_i(RSTN_I), .gclk_o(GLOBAL_CLOCK_LINES_I));
  always #10 CLK_I = ~CLK_I;
  task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(string nm, logic e, logic g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask
  // one cycle of port requests, launched at a rising edge
  task automatic drv(logic ae, awe, logic [11:0] aa, logic [7:0] ad, logic be, logic [11:0] ba);
    @(posedge CLK_I);
    A_EN_I <= ae;
    A_WE_I <= awe;
    A_ADDR_I <= aa;
    A_DATA_I <= ad;
    B_EN_I <= be;
    B_ADDR_I <= ba;
  endtask
  // fifo push/pop held across exactly one rising edge of global clock 0
  task automatic fclk(logic push, logic [7:0] d, logic pop);
    @(posedge GLOBAL_CLOCK_LINES_I[0]);
    @(posedge CLK_I);
    A_WE_I <= push;
    A_DATA_I <= d;
    B_EN_I <= pop;
    repeat (4) @(posedge CLK_I);
    A_WE_I <= 1'b0;
    B_EN_I <= 1'b0;
    repeat (2) @(negedge CLK_I);
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (6000) @(posedge CLK_I);
    fails++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(negedge CLK_I);
    chk8("a_data_rst", 8'h00, A_DATA_O);
    chk1("match_n_rst", 1'b1, MATCH_N_O);
    @(posedge CLK_I);
    RSTN_I <= 1'b1;
    @(posedge CLK_I);
    CFG_I <= 1'b1;
    CFG_WE_I <= 1'b1;
    CFG_ADDR_I <= 10'h005;
    CFG_DATA_I <= 8'h3E;
    @(posedge CLK_I);
    CFG_I <= 1'b0;
    CFG_WE_I <= 1'b0;
    drv(1'b1, 1'b0, 12'h005, 8'h00, 1'b0, 12'h000);
    drv(1'b0, 1'b0, 12'h000, 8'h00, 1'b0, 12'h000);
    @(negedge CLK_I);
    chk8("cfg_load", 8'h3E, A_DATA_O);
    foreach (rows[i]) begin
      drv(1'b1, 1'b1, rows[i][19:8], rows[i][7:0], 1'b0, 12'h000);
      drv(1'b0, 1'b0, 12'h000, 8'h00, 1'b1, rows[i][19:8]);
      drv(1'b0, 1'b0, 12'h000, 8'h00, 1'b0, 12'h000);
      @(negedge CLK_I);
      chk8("b_read", rows[i][7:0], B_DATA_O);
    end
    drv(1'b1, 1'b1, 12'h000, 8'h3C, 1'b1, 12'h000);
    @(negedge CLK_I);
    chk1("match_n", 1'b0, MATCH_N_O);
    @(negedge CLK_I);
    chk8("b_old", 8'hA5, B_DATA_O);
    drv(1'b0, 1'b0, 12'h000, 8'h00, 1'b0, 12'h000);
    @(negedge CLK_I);
    chk8("b_new", 8'h3C, B_DATA_O);
    @(posedge CLK_I);
    MODE_I <= CDPF_ROM;
    drv(1'b1, 1'b1, 12'h000, 8'hFF, 1'b0, 12'h000);
    drv(1'b1, 1'b0, 12'h000, 8'h00, 1'b0, 12'h000);
    drv(1'b0, 1'b0, 12'h000, 8'h00, 1'b0, 12'h000);
    @(negedge CLK_I);
    chk8("rom_keep", 8'h3C, A_DATA_O);
    // synchronous dual-port: both ports strobe on the same global clock edge
    @(posedge CLK_I);
    MODE_I <= CDPF_DPRAM;
    SYNC_I <= 1'b1;
    A_EN_I <= 1'b1;
    A_ADDR_I <= 12'h033;
    B_ADDR_I <= 12'h033;
    fclk(1'b1, 8'h77, 1'b1);
    chk8("b_sync_new", 8'h77, B_DATA_O);
    fclk(1'b0, 8'h00, 1'b1);
    chk8("rr_a", 8'h77, A_DATA_O);
    chk8("rr_b", 8'h77, B_DATA_O);
    @(posedge CLK_I);
    B_WE_I <= 1'b1;
    B_DATA_I <= 8'h22;
    fclk(1'b1, 8'h11, 1'b1);
    chk8("ww_last", 8'h22, A_DATA_O);
    // output register loads on its clock, then clears without it
    @(posedge CLK_I);
    B_WE_I <= 1'b0;
    A_OREG_EN_I <= 1'b1;
    repeat (8) @(posedge CLK_I);
    @(negedge CLK_I);
    chk8("a_oreg", 8'h22, A_DATA_O);
    @(posedge CLK_I);
    OREG_RST_I <= 1'b1;
    @(negedge CLK_I);
    chk8("a_oreg_clr", 8'h00, A_DATA_O);
    @(posedge CLK_I);
    OREG_RST_I <= 1'b0;
    A_OREG_EN_I <= 1'b0;
    MODE_I <= CDPF_FIFO;
    ALMOST_THR_I <= 12'h001;
    fclk(1'b0, 8'h00, 1'b1);
    chk1("ef_n_empty", 1'b0, EMPTY_OR_FULL_FLAG_N_O);
    fclk(1'b1, 8'h96, 1'b0);
    chk1("ef_n_one", 1'b1, EMPTY_OR_FULL_FLAG_N_O);
    chk1("almost_one", 1'b1, ALMOST_LEVEL_FLAG_O);
    fclk(1'b1, 8'h69, 1'b0);
    chk1("almost_two", 1'b0, ALMOST_LEVEL_FLAG_O);
    chk1("hf_n_two", 1'b1, HALF_LEVEL_FLAG_N_O);
    fclk(1'b0, 8'h00, 1'b1);
    chk8("pop_data", 8'h96, B_DATA_O);
    // fill to full with push held; extra pushes must be refused
    @(posedge CLK_I);
    A_WE_I <= 1'b1;
    repeat (3120) @(posedge CLK_I);
    A_WE_I <= 1'b0;
    @(negedge CLK_I);
    chk1("ef_n_full", 1'b0, EMPTY_OR_FULL_FLAG_N_O);
    chk1("hf_n_full", 1'b0, HALF_LEVEL_FLAG_N_O);
    chk1("almost_full", 1'b1, ALMOST_LEVEL_FLAG_O);
    fclk(1'b0, 8'h00, 1'b1);
    chk8("pop_after_full", 8'h69, B_DATA_O);
    chk1("ef_n_less", 1'b1, EMPTY_OR_FULL_FLAG_N_O);
    // cluster block: x4 lane write, then rom mode keeps it
    @(posedge CLK_I);
    CL_WIDTH_I <= CDPF_X4;
    CL_EN_I <= 1'b1;
    CL_WE_I <= 1'b1;
    CL_ADDR_I <= 13'h0001;
    CL_DATA_I <= 8'h0B;
    @(posedge CLK_I);
    CL_WE_I <= 1'b0;
    @(posedge CLK_I);
    @(negedge CLK_I);
    chk8("cl_lane", 8'h0B, CL_DATA_O);
    @(posedge CLK_I);
    CL_ROM_I <= 1'b1;
    CL_WE_I <= 1'b1;
    CL_DATA_I <= 8'h04;
    repeat (2) @(posedge CLK_I);
    @(negedge CLK_I);
    chk8("cl_rom_keep", 8'h0B, CL_DATA_O);
    tally_and_finish();
  end
endmodule
